// ---- irq_source_pkg.sv ----
// Purpose: shared constants and types of the interrupt source logic
// Assumes: 8-bit register port, one clock edge per oscillator phase
// Notes: register addresses are word indices on the plain register port
package irq_source_pkg;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_OPTION = 4'h1;
   localparam logic [3:0] ADDR_TIMER = 4'h2;
   localparam logic [3:0] ADDR_PORT = 4'h3;
   localparam logic [3:0] ADDR_EVT_STATUS = 4'h4;
   localparam logic [3:0] ADDR_EVT_CLEAR = 4'h5;
   localparam logic [3:0] ADDR_EVT_ENABLE = 4'h6;
   localparam logic [3:0] ADDR_SEQ_STATUS = 4'h7;
   localparam int EDGE_SELECT_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [7:0] TIMER_RESET = 8'h00;
   localparam logic [7:0] TIMER_MAX = 8'hFF;
   localparam logic [3:0] EVT_RESET = 4'h0;
   localparam logic [12:0] VECTOR_ADDR = 13'h0004;
   localparam int PORT_PINS = 4;
   localparam int EVT_BITS = 4;
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_type;
   typedef enum logic [2:0] {SEQ_RUN, SEQ_SLEEP, SEQ_FINISH, SEQ_DUMMY1, SEQ_DUMMY2} seq_type;
   // interrupt control register, bit 7 down to bit 0
   typedef struct packed {
      logic global_irq_enable;
      logic spare;
      logic timer_en;
      logic ext_en;
      logic port_en;
      logic timer_flag;
      logic ext_flag;
      logic port_flag;
   } irq_ctrl_type;
   // strobes toward the core sequencer
   typedef struct packed {
      logic discard;
      logic dummy;
      logic pc_load;
      logic vector_start;
      logic wake;
      logic cont;
   } entry_type;
endpackage

// ---- sync_two_flop.sv ----
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are levels from outside the clock domain
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_reg <= '0;
         sync_o <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ---- irq_source_logic.sv ----
// Purpose: interrupt sources, flags, enables, sleep wake-up and vector entry of a small 8-bit core
// Assumes: one clock edge per oscillator phase, four phases per instruction cycle
// Notes: register reads return data in the following cycle only
// Overview of operation
// - the pin interrupt fires on a rising edge when edge select is one, falling edge when zero.
// - a valid edge on the pin sets the pin flag in the control register.
// - a cleared pin enable keeps the pin flag from requesting an interrupt.
// - a pin edge wakes the core from sleep if the pin enable was set before sleep.
// - after wake-up the core vectors only when the global enable is set, else it continues.
// - the timer rolling over from its maximum to zero sets the timer flag.
// - the timer enable bit lets the timer flag request an interrupt or blocks it.
// - any level change on the four upper port pins sets the port change flag.
// - the port change enable bit lets the port flag request an interrupt or blocks it.
// - a pin change coinciding with a port read may leave the port flag unset.
// - the vector starts 3 to 4 instruction cycles after the pin flag sets, for any instruction.
// - the sequencer samples the flags once per instruction cycle, in the first phase.
// - the pin flag may only become set from the fourth phase through the next first phase.
// - an interrupt taken with global enable loads the program counter with the vector.
`timescale 1ns/1ps
`default_nettype none
module irq_source_logic #(
   parameter int PC_WIDTH = 13
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic ext_irq_pin_i,
   input wire logic [irq_source_pkg::PORT_PINS-1:0] port_pins_i,
   input wire logic sleep_i,
   input wire logic retfie_i,
   output logic [1:0] phase_o,
   output logic cpu_irq_o,
   output logic sleeping_o,
   output logic wake_o,
   output logic continue_o,
   output logic discard_fetch_o,
   output logic dummy_cycle_o,
   output logic pc_load_o,
   output logic [PC_WIDTH-1:0] pc_vector_o,
   output logic vector_start_o,
   output logic irq_o
);
   logic [0:0] ext_sync;
   logic [irq_source_pkg::PORT_PINS-1:0] port_sync;

   sync_two_flop #(.WIDTH(1)) u_ext_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .async_i(ext_irq_pin_i),
      .sync_o(ext_sync)
   );
   sync_two_flop #(.WIDTH(irq_source_pkg::PORT_PINS)) u_port_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .async_i(port_pins_i),
      .sync_o(port_sync)
   );

   // phase counter and pin edge capture
   irq_source_pkg::phase_type phase_reg, phase_next;
   logic ext_prev_reg, ext_prev_next;
   logic edge_pend_reg, edge_pend_next;
   logic [7:0] option_reg, option_next;
   logic ext_edge, flag_window, ext_set;

   always_comb begin
      case (phase_reg)
         irq_source_pkg::PH_Q1: phase_next = irq_source_pkg::PH_Q2;
         irq_source_pkg::PH_Q2: phase_next = irq_source_pkg::PH_Q3;
         irq_source_pkg::PH_Q3: phase_next = irq_source_pkg::PH_Q4;
         irq_source_pkg::PH_Q4: phase_next = irq_source_pkg::PH_Q1;
         default: phase_next = irq_source_pkg::PH_Q1;
      endcase
      ext_prev_next = ext_sync[0];
      if (option_reg[irq_source_pkg::EDGE_SELECT_BIT]) begin
         ext_edge = ext_sync[0] & ~ext_prev_reg;
      end else begin
         ext_edge = ~ext_sync[0] & ext_prev_reg;
      end
      flag_window = (phase_reg == irq_source_pkg::PH_Q4) || (phase_reg == irq_source_pkg::PH_Q1);
      // an edge outside the window waits for it instead of being lost
      ext_set = flag_window & (edge_pend_reg | ext_edge);
      edge_pend_next = (edge_pend_reg | ext_edge) & ~flag_window;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         phase_reg <= irq_source_pkg::PH_Q1;
         ext_prev_reg <= 1'b0;
         edge_pend_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         ext_prev_reg <= ext_prev_next;
         edge_pend_reg <= edge_pend_next;
      end
   end

   // sequencer signals used by the register group
   irq_source_pkg::seq_type state_reg, state_next;
   logic entry_take;
   logic sleep_ext_en_reg, sleep_ext_en_next;

   // register group
   irq_source_pkg::irq_ctrl_type ctrl_reg, ctrl_next;
   logic [7:0] timer_reg, timer_next;
   logic [irq_source_pkg::PORT_PINS-1:0] port_last_reg, port_last_next;
   logic [irq_source_pkg::EVT_BITS-1:0] evt_status_reg, evt_status_next;
   logic [irq_source_pkg::EVT_BITS-1:0] evt_enable_reg, evt_enable_next;
   logic [7:0] rdata_next;
   logic irq_next;
   logic ctrl_wr, timer_wr, port_rd, timer_ovf, port_chg;
   logic [irq_source_pkg::EVT_BITS-1:0] evt_clear, evt_set;

   always_comb begin
      ctrl_wr = wr_i && (addr_i == irq_source_pkg::ADDR_CTRL);
      timer_wr = wr_i && (addr_i == irq_source_pkg::ADDR_TIMER);
      port_rd = rd_i && (addr_i == irq_source_pkg::ADDR_PORT);
      option_next = option_reg;
      if (wr_i && (addr_i == irq_source_pkg::ADDR_OPTION)) begin
         option_next = wdata_i;
      end
      // timer advances once per instruction cycle
      timer_ovf = 1'b0;
      timer_next = timer_reg;
      if (timer_wr) begin
         timer_next = wdata_i;
      end else if (phase_reg == irq_source_pkg::PH_Q4) begin
         timer_next = timer_reg + 8'h01;
         timer_ovf = (timer_reg == irq_source_pkg::TIMER_MAX);
      end
      port_chg = (port_sync != port_last_reg) && !port_rd;
      port_last_next = port_rd ? port_sync : port_last_reg;
      // flags change only by software write or by hardware set
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         ctrl_next = irq_source_pkg::irq_ctrl_type'(wdata_i);
      end
      if (retfie_i) begin
         ctrl_next.global_irq_enable = 1'b1;
      end
      if (entry_take) begin
         ctrl_next.global_irq_enable = 1'b0;
      end
      // pin flag set, wins over a clear
      ctrl_next.ext_flag = ctrl_next.ext_flag | ext_set;
      ctrl_next.timer_flag = ctrl_next.timer_flag | timer_ovf;
      ctrl_next.port_flag = ctrl_next.port_flag | port_chg;
      // event status: set wins over clear
      evt_set = {entry_take, port_chg, timer_ovf, ext_set};
      evt_clear = '0;
      if (wr_i && (addr_i == irq_source_pkg::ADDR_EVT_CLEAR)) begin
         evt_clear = wdata_i[irq_source_pkg::EVT_BITS-1:0];
      end
      evt_status_next = (evt_status_reg & ~evt_clear) | evt_set;
      evt_enable_next = evt_enable_reg;
      if (wr_i && (addr_i == irq_source_pkg::ADDR_EVT_ENABLE)) begin
         evt_enable_next = wdata_i[irq_source_pkg::EVT_BITS-1:0];
      end
      irq_next = |(evt_status_next & evt_enable_next);
      rdata_next = 8'h00;
      if (rd_i) begin
         case (addr_i)
            irq_source_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
            irq_source_pkg::ADDR_OPTION: rdata_next = option_reg;
            irq_source_pkg::ADDR_TIMER: rdata_next = timer_reg;
            irq_source_pkg::ADDR_PORT: rdata_next = {port_sync, 4'h0};
            irq_source_pkg::ADDR_EVT_STATUS: rdata_next = {4'h0, evt_status_reg};
            irq_source_pkg::ADDR_EVT_ENABLE: rdata_next = {4'h0, evt_enable_reg};
            irq_source_pkg::ADDR_SEQ_STATUS: rdata_next = {4'h0, sleep_ext_en_reg, state_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_reg <= irq_source_pkg::irq_ctrl_type'(irq_source_pkg::CTRL_RESET);
         option_reg <= irq_source_pkg::OPTION_RESET;
         timer_reg <= irq_source_pkg::TIMER_RESET;
         port_last_reg <= '0;
         evt_status_reg <= irq_source_pkg::EVT_RESET;
         evt_enable_reg <= irq_source_pkg::EVT_RESET;
         rdata_o <= 8'h00;
         irq_o <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         option_reg <= option_next;
         timer_reg <= timer_next;
         port_last_reg <= port_last_next;
         evt_status_reg <= evt_status_next;
         evt_enable_reg <= evt_enable_next;
         rdata_o <= rdata_next;
         irq_o <= irq_next;
      end
   end

   // entry sequencer
   irq_source_pkg::entry_type out_next;
   logic [PC_WIDTH-1:0] vector_next;
   logic req, wake_cond, q1, q4;

   always_comb begin
      q1 = (phase_reg == irq_source_pkg::PH_Q1);
      q4 = (phase_reg == irq_source_pkg::PH_Q4);
      req = ctrl_reg.global_irq_enable && ((ctrl_reg.ext_flag && ctrl_reg.ext_en) ||
            (ctrl_reg.timer_flag && ctrl_reg.timer_en) || (ctrl_reg.port_flag && ctrl_reg.port_en));
      // pin wake needs the enable held at sleep entry
      wake_cond = (ctrl_reg.ext_flag && sleep_ext_en_reg) ||
                  (ctrl_reg.timer_flag && ctrl_reg.timer_en) || (ctrl_reg.port_flag && ctrl_reg.port_en);
      state_next = state_reg;
      sleep_ext_en_next = sleep_ext_en_reg;
      entry_take = 1'b0;
      out_next = '0;
      vector_next = pc_vector_o;
      case (state_reg)
         irq_source_pkg::SEQ_RUN: begin
            if (sleep_i) begin
               state_next = irq_source_pkg::SEQ_SLEEP;
               sleep_ext_en_next = ctrl_reg.ext_en;
            end else if (q1 && req) begin
               entry_take = 1'b1;
               state_next = irq_source_pkg::SEQ_FINISH;
            end
         end
         irq_source_pkg::SEQ_SLEEP: begin
            if (q1 && wake_cond) begin
               out_next.wake = 1'b1;
               if (ctrl_reg.global_irq_enable) begin
                  entry_take = 1'b1;
                  state_next = irq_source_pkg::SEQ_FINISH;
               end else begin
                  out_next.cont = 1'b1;
                  state_next = irq_source_pkg::SEQ_RUN;
               end
            end
         end
         irq_source_pkg::SEQ_FINISH: begin
            if (q4) begin
               out_next.discard = 1'b1;
               state_next = irq_source_pkg::SEQ_DUMMY1;
            end
         end
         irq_source_pkg::SEQ_DUMMY1: begin
            if (q4) begin
               out_next.pc_load = 1'b1;
               vector_next = PC_WIDTH'(irq_source_pkg::VECTOR_ADDR);
               state_next = irq_source_pkg::SEQ_DUMMY2;
            end
         end
         irq_source_pkg::SEQ_DUMMY2: begin
            if (q4) begin
               // fixed path, length independent of the instruction
               out_next.vector_start = 1'b1;
               state_next = irq_source_pkg::SEQ_RUN;
            end
         end
         default: state_next = irq_source_pkg::SEQ_RUN;
      endcase
      out_next.dummy = (state_next == irq_source_pkg::SEQ_DUMMY1) || (state_next == irq_source_pkg::SEQ_DUMMY2);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= irq_source_pkg::SEQ_RUN;
         sleep_ext_en_reg <= 1'b0;
         phase_o <= 2'h0;
         cpu_irq_o <= 1'b0;
         sleeping_o <= 1'b0;
         wake_o <= 1'b0;
         continue_o <= 1'b0;
         discard_fetch_o <= 1'b0;
         dummy_cycle_o <= 1'b0;
         pc_load_o <= 1'b0;
         pc_vector_o <= '0;
         vector_start_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         sleep_ext_en_reg <= sleep_ext_en_next;
         phase_o <= phase_next;
         cpu_irq_o <= req;
         sleeping_o <= (state_next == irq_source_pkg::SEQ_SLEEP);
         wake_o <= out_next.wake;
         continue_o <= out_next.cont;
         discard_fetch_o <= out_next.discard;
         dummy_cycle_o <= out_next.dummy;
         pc_load_o <= out_next.pc_load;
         pc_vector_o <= vector_next;
         vector_start_o <= out_next.vector_start;
      end
   end

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   logic rise_sel;
   assign rise_sel = option_reg[irq_source_pkg::EDGE_SELECT_BIT];

   a_edge_rising: assert property ((rise_sel && $rose(ext_sync[0]) && flag_window) |=> ctrl_reg.ext_flag)
      else $error("rising edge did not set pin flag");
   a_edge_sets_flag: assert property (ext_set && !entry_take |=> ctrl_reg.ext_flag && evt_status_reg[0])
      else $error("pin edge lost");
   a_ext_masked: assert property ((ctrl_reg.ext_flag && !ctrl_reg.ext_en && !ctrl_reg.timer_flag
      && !ctrl_reg.port_flag) |-> !entry_take)
      else $error("masked pin flag started entry");
   a_wake_pin: assert property ((state_reg == irq_source_pkg::SEQ_SLEEP && q1 && ctrl_reg.ext_flag
      && sleep_ext_en_reg) |=> wake_o)
      else $error("pin flag did not wake core");
   a_wake_no_gie: assert property ((state_reg == irq_source_pkg::SEQ_SLEEP && q1 && wake_cond && !ctrl_reg.global_irq_enable)
      |=> continue_o && !dummy_cycle_o ##4 !discard_fetch_o)
      else $error("wake without global enable did not continue");
   a_timer_rollover: assert property ((timer_reg == irq_source_pkg::TIMER_MAX && q4 && !timer_wr)
      |=> timer_reg == 8'h00 && ctrl_reg.timer_flag)
      else $error("timer rollover did not set flag");
   a_timer_masked: assert property ((ctrl_reg.timer_flag && !ctrl_reg.timer_en && !ctrl_reg.ext_flag
      && !ctrl_reg.port_flag) |-> !entry_take)
      else $error("masked timer flag started entry");
   a_port_change: assert property ((port_sync != port_last_reg && !port_rd) |=> ctrl_reg.port_flag)
      else $error("port change did not set flag");
   a_port_masked: assert property ((ctrl_reg.port_flag && !ctrl_reg.port_en && !ctrl_reg.ext_flag
      && !ctrl_reg.timer_flag) |-> !entry_take)
      else $error("masked port flag started entry");
   a_port_read_latch: assert property (port_rd |=> port_last_reg == $past(port_sync))
      else $error("port read did not refresh compare latch");
   a_entry_latency: assert property (($rose(ctrl_reg.ext_flag) && ctrl_reg.ext_en && ctrl_reg.global_irq_enable
      && state_reg == irq_source_pkg::SEQ_RUN && !sleep_i && !retfie_i) |-> ##[12:15] vector_start_o)
      else $error("vector not reached in 3 to 4 instruction cycles");
   a_sample_first_phase: assert property (entry_take |-> phase_reg == irq_source_pkg::PH_Q1)
      else $error("entry taken outside first phase");
   a_flag_window: assert property ($rose(ctrl_reg.ext_flag) |-> $past(flag_window) || $past(ctrl_wr))
      else $error("pin flag set outside its window");
   a_vector_load: assert property (pc_load_o |-> pc_vector_o == PC_WIDTH'(irq_source_pkg::VECTOR_ADDR)
      ##4 vector_start_o)
      else $error("wrong vector or timing");
   a_entry_clears_gie: assert property (entry_take |=> !ctrl_reg.global_irq_enable)
      else $error("global enable not cleared on entry");
   a_two_dummies: assert property (discard_fetch_o |-> dummy_cycle_o [*8] ##1 vector_start_o)
      else $error("entry did not insert two dummy cycles");

   c_vector_entry: cover property (vector_start_o);
   c_wake_continue: cover property (wake_o && continue_o);
   c_read_absorbs: cover property (port_rd && port_sync != port_last_reg);
   c_timer_wrap: cover property (timer_ovf && ctrl_reg.timer_en);
endmodule
`default_nettype wire

// ---- irq_core_model.sv ----
// Purpose: far-side model: external pin driver and core sleep/return strobes
// Assumes: all outputs change just after a rising clock edge
// Notes: pins are plain levels; the core strobes are one cycle long
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
   input wire logic clk_i,
   output logic ext_irq_pin_o,
   output logic [3:0] port_pins_o,
   output logic sleep_o,
   output logic retfie_o
);
   initial begin
      ext_irq_pin_o = 1'b0;
      port_pins_o = 4'h0;
      sleep_o = 1'b0;
      retfie_o = 1'b0;
   end
   task automatic pin_set(input logic lvl);
      @(posedge clk_i) ext_irq_pin_o <= lvl;
   endtask
   task automatic port_set(input logic [3:0] v);
      @(posedge clk_i) port_pins_o <= v;
   endtask
   task automatic sleep_pulse();
      @(posedge clk_i) sleep_o <= 1'b1;
      @(posedge clk_i) sleep_o <= 1'b0;
   endtask
   // core return from a service routine, restores the global enable
   task automatic retfie_pulse();
      @(posedge clk_i) retfie_o <= 1'b1;
      @(posedge clk_i) retfie_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- test_irq_source_logic.sv ----
// Purpose: self-checking bench of the interrupt source logic
// Assumes: register port and far-side model driven after rising edges
// Notes: each scenario is one task; the partner model drives pins and sleep
`timescale 1ns/1ps
`default_nettype none
module test_irq_source_logic;
   logic clk_i, srst_i, wr_i, rd_i;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o, rd_val;
   logic ext_pin, sleep_s, retfie_s, cpu_irq_o, sleeping_o, wake_o, continue_o;
   logic discard_fetch_o, dummy_cycle_o, pc_load_o, vector_start_o, irq_o;
   logic [3:0] port_pins;
   logic [1:0] phase_o;
   logic [12:0] pc_vector_o;
   logic [6:0] evts;
   int err_total, checks;
   irq_core_model far(.clk_i(clk_i), .ext_irq_pin_o(ext_pin), .port_pins_o(port_pins),
      .sleep_o(sleep_s), .retfie_o(retfie_s));
   irq_source_logic dut(.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_irq_pin_i(ext_pin), .port_pins_i(port_pins),
      .sleep_i(sleep_s), .retfie_i(retfie_s), .phase_o(phase_o), .cpu_irq_o(cpu_irq_o),
      .sleeping_o(sleeping_o), .wake_o(wake_o), .continue_o(continue_o),
      .discard_fetch_o(discard_fetch_o), .dummy_cycle_o(dummy_cycle_o), .pc_load_o(pc_load_o),
      .pc_vector_o(pc_vector_o), .vector_start_o(vector_start_o), .irq_o(irq_o));
   assign evts = {irq_o, discard_fetch_o, vector_start_o, wake_o, pc_load_o, cpu_irq_o, sleeping_o};
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic final_report();
      $display("mismatches %0d comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i) begin
         wr_i <= 1'b1;
         addr_i <= a;
         wdata_i <= d;
      end
      @(posedge clk_i) wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a);
      @(posedge clk_i) begin
         rd_i <= 1'b1;
         addr_i <= a;
      end
      @(posedge clk_i) rd_i <= 1'b0;
      #1 rd_val = rdata_o;
   endtask
   task automatic rd_cmp(input logic [3:0] a, input logic [7:0] exp, input string what);
      reg_rd(a);
      cmp8(rd_val, exp, what);
   endtask
   // waits a bounded number of cycles for one output of the evts vector
   task automatic wait_evt(input int idx, input int lim, input string what);
      int n;
      n = 0;
      while (evts[idx] !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         #1 n++;
      end
      cmp8({7'h00, evts[idx]}, 8'h01, what);
   endtask
   task automatic t_reset();
      rd_cmp(irq_source_pkg::ADDR_CTRL, irq_source_pkg::CTRL_RESET, "ctrl reset");
      rd_cmp(irq_source_pkg::ADDR_OPTION, irq_source_pkg::OPTION_RESET, "option reset");
      rd_cmp(irq_source_pkg::ADDR_EVT_CLEAR, 8'h00, "clear reads zero");
      rd_cmp(4'h9, 8'h00, "unmapped reads zero");
   endtask
   task automatic t_edges();
      far.pin_set(1'b1);
      repeat (10) @(posedge clk_i);
      rd_cmp(irq_source_pkg::ADDR_CTRL, 8'h02, "rising edge flag");
      reg_wr(irq_source_pkg::ADDR_CTRL, 8'h80);
      reg_wr(irq_source_pkg::ADDR_OPTION, 8'hBF);
      far.pin_set(1'b0);
      repeat (10) @(posedge clk_i);
      #1 cmp8({7'h00, cpu_irq_o}, 8'h00, "disabled pin request");
      rd_cmp(irq_source_pkg::ADDR_CTRL, 8'h82, "falling edge flag");
      far.pin_set(1'b1);
      reg_wr(irq_source_pkg::ADDR_CTRL, 8'h00);
      repeat (10) @(posedge clk_i);
      rd_cmp(irq_source_pkg::ADDR_CTRL, 8'h00, "rising ignored");
      far.pin_set(1'b0);
      repeat (10) @(posedge clk_i);
   endtask
   // flag is already set when enables are written, so entry follows at once
   task automatic t_entry();
      int n, pl;
      reg_wr(irq_source_pkg::ADDR_CTRL, 8'h92);
      wait_evt(5, 20, "discard fetch");
      n = 0;
      pl = 0;
      while (dummy_cycle_o === 1'b1 && n < 20) begin
         if (pc_load_o === 1'b1) begin
            pl = n;
         end
         @(posedge clk_i);
         #1 n++;
      end
      cmp8(n[7:0], 8'h08, "dummy cycles");
      cmp8(pl[7:0], 8'h04, "pc load in second dummy cycle");
      cmp8({7'h00, vector_start_o}, 8'h01, "vector start");
      cmp8({6'h00, phase_o}, 8'h00, "vector in first phase");
      cmp8(pc_vector_o[7:0], 8'h04, "vector address");
      rd_cmp(irq_source_pkg::ADDR_CTRL, 8'h12, "entry clears global");
   endtask
   // flag cleared before the global enable returns, then a pin edge while running
   task automatic t_latency();
      reg_wr(irq_source_pkg::ADDR_CTRL, 8'h10);
      far.retfie_pulse();
      rd_cmp(irq_source_pkg::ADDR_CTRL, 8'h90, "return sets global");
      far.pin_set(1'b1);
      repeat (4) @(posedge clk_i);
      far.pin_set(1'b0);
      wait_evt(4, 18, "vector latency from pin");
      rd_cmp(irq_source_pkg::ADDR_CTRL, 8'h12, "flag kept after entry");
   endtask
   task automatic t_timer();
      reg_wr(irq_source_pkg::ADDR_EVT_CLEAR, 8'h0F);
      reg_wr(irq_source_pkg::ADDR_CTRL, 8'h80);
      reg_wr(irq_source_pkg::ADDR_TIMER, 8'hFE);
      repeat (12) @(posedge clk_i);
      #1 cmp8({7'h00, cpu_irq_o}, 8'h00, "timer request blocked");
      rd_cmp(irq_source_pkg::ADDR_CTRL, 8'h84, "timer overflow flag");
      rd_cmp(irq_source_pkg::ADDR_EVT_STATUS, 8'h02, "overflow event");
      reg_wr(irq_source_pkg::ADDR_EVT_ENABLE, 8'h02);
      wait_evt(6, 3, "event interrupt");
      reg_wr(irq_source_pkg::ADDR_EVT_ENABLE, 8'h00);
      #1 cmp8({7'h00, irq_o}, 8'h00, "event masked");
      reg_wr(irq_source_pkg::ADDR_EVT_ENABLE, 8'h02);
      reg_wr(irq_source_pkg::ADDR_EVT_CLEAR, 8'h02);
      #1 cmp8({7'h00, irq_o}, 8'h00, "event cleared");
      rd_cmp(irq_source_pkg::ADDR_EVT_STATUS, 8'h00, "status after clear");
      reg_wr(irq_source_pkg::ADDR_CTRL, 8'hA4);
      wait_evt(1, 8, "timer request");
      wait_evt(4, 20, "timer vector");
   endtask
   task automatic t_port();
      reg_wr(irq_source_pkg::ADDR_CTRL, 8'h00);
      reg_rd(irq_source_pkg::ADDR_PORT);
      far.port_set(4'hA);
      repeat (8) @(posedge clk_i);
      rd_cmp(irq_source_pkg::ADDR_CTRL, 8'h01, "port change flag");
      reg_wr(irq_source_pkg::ADDR_CTRL, 8'h89);
      wait_evt(1, 8, "port request");
      wait_evt(4, 20, "port vector");
   endtask
   task automatic t_sleep(input logic [7:0] ctrl, input logic exp_cont);
      far.pin_set(1'b1);
      repeat (8) @(posedge clk_i);
      reg_wr(irq_source_pkg::ADDR_CTRL, ctrl);
      far.sleep_pulse();
      wait_evt(0, 3, "sleeping");
      far.pin_set(1'b0);
      wait_evt(3, 16, "wake on pin");
      cmp8({7'h00, continue_o}, {7'h00, exp_cont}, "continue after wake");
      if (!exp_cont) begin
         wait_evt(4, 20, "vector after wake");
      end
   endtask
   initial begin
      srst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      err_total = 0;
      checks = 0;
      repeat (20) @(posedge clk_i);
      srst_i <= 1'b0;
      t_reset();
      t_edges();
      t_entry();
      t_latency();
      t_timer();
      t_port();
      t_sleep(8'h10, 1'b1);
      t_sleep(8'h90, 1'b0);
      final_report();
   end
   // whole run is a few hundred cycles; this span is ample
   initial begin
      #200000;
      err_total++;
      final_report();
   end
endmodule
`default_nettype wire
